/* rtl/amp_cfg_pkg.sv */
// amp_cfg_pkg: constants and types for the amplifier configuration serial port
// assumes a single system clock; serial pins are synchronous samples of it
package amp_cfg_pkg;
  localparam int CFG_WIDTH = 5;
  localparam int BIT_GAIN_HI = 4;
  localparam int BIT_GAIN_LO = 3;
  localparam int BIT_AMP_EN = 2;
  localparam int BIT_NULL = 1;
  localparam int BIT_TRISTATE = 0;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [2:0] SEL_G0096 = 3'h0;
  localparam logic [2:0] SEL_G0192 = 3'h1;
  localparam logic [2:0] SEL_G0384 = 3'h2;
  localparam logic [2:0] SEL_G0768 = 3'h3;
  localparam logic [2:0] SEL_G1 = 3'h4;
  localparam logic [2:0] SEL_G2 = 3'h5;
  localparam logic [2:0] SEL_UNITY = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;

  typedef struct packed {
    logic gain_hi;
    logic gain_lo;
    logic amplify_enable;
    logic offset_null_sel;
    logic output_tristate;
  } amp_configuration_t;

  typedef struct packed {
    logic [2:0] gain_sel;
    logic atten_path;
    logic amp_path;
    logic null_path;
    logic out_enable;
  } amp_mode_t;

  typedef enum logic [1:0] {
    PORT_IDLE = 2'b01,
    PORT_SHIFT = 2'b10
  } port_state_t;
endpackage

/* rtl/amp_cfg_hold.sv */
// amp_cfg_hold: holding register for the applied configuration word
// assumes the caller raises load_in for one cycle per completed write
`timescale 1ns/10ps
module amp_cfg_hold
  import amp_cfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic load_in,
  input wire amp_configuration_t data_in,
  output amp_configuration_t hold_out
);
  // R14 zero until written
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hold_out <= amp_configuration_t'(CFG_RESET);
    end else if (load_in) begin
      hold_out <= data_in;
    end
  end
endmodule

/* rtl/amp_config_serial_port.sv */
// amp_config_serial_port: 5-bit serial configuration port with daisy-chain output
// assumes sck, chip select and sdi are already synchronous to clk_in
//
// Behaviour
// R1 - tristate bit disables both outputs
// R2 - otherwise mode follows other four bits
// R3 - five bits, gain hi first, tristate last
// R4 - gain decode for attenuation and amplification
// R5 - null bit: inputs off, unity gain
// R6 - serial out is shift register's last bit
// R7 - host may share or split chip select
// R8 - host gives ten clocks for two devices
// R9 - access starts only on select fall, sck high
// R10 - select fall with sck low changes nothing
// R11 - shared host starts conversions with sck low
// R12 - shift on rising sck while selected
// R13 - select rise loads holding register
// R14 - holding register zero before first write
`timescale 1ns/10ps
module amp_config_serial_port
  import amp_cfg_pkg::*;
#(
  parameter int WIDTH = CFG_WIDTH
)(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic sck_in,
  input wire logic chip_select_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output amp_configuration_t config_out,
  output amp_mode_t mode_out,
  output logic analog_oe_n_out
);
  logic sck_q;
  logic cs_q;
  logic [WIDTH-1:0] shift;
  port_state_t state;
  amp_configuration_t hold;
  logic load;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;

  assign cs_fall = cs_q && !chip_select_n_in;
  assign cs_rise = !cs_q && chip_select_n_in;
  assign sck_rise = !sck_q && sck_in;

  function automatic amp_mode_t decode(input amp_configuration_t c);
    amp_mode_t m;
    m = '0;
    if (c.output_tristate) begin
      // R1 tristate overrides all
      m.gain_sel = SEL_NONE;
      m.out_enable = 1'b0;
    end else if (c.offset_null_sel) begin
      // R5 null unity gain
      m.gain_sel = SEL_UNITY;
      m.null_path = 1'b1;
      m.out_enable = 1'b1;
    end else begin
      // R2 R4 gain decode
      m.out_enable = 1'b1;
      if (!c.amplify_enable) begin
        m.atten_path = 1'b1;
        case ({c.gain_hi, c.gain_lo})
          2'b00: m.gain_sel = SEL_G0096;
          2'b01: m.gain_sel = SEL_G0192;
          2'b10: m.gain_sel = SEL_G0384;
          default: m.gain_sel = SEL_G0768;
        endcase
      end else begin
        // codes 0x/1 unlisted: treated as gain 1 / 2 by low bit
        m.amp_path = 1'b1;
        m.gain_sel = c.gain_lo ? SEL_G2 : SEL_G1;
      end
    end
    return m;
  endfunction

  // pins tracked through reset too, so release shows no false edge
  always_ff @(posedge clk_in) begin
    sck_q <= sck_in;
    cs_q <= chip_select_n_in;
  end

  // R9 R10 qualified select fall
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state <= PORT_IDLE;
    end else begin
      case (state)
        PORT_IDLE: begin
          if (cs_fall && sck_q && sck_in) begin
            state <= PORT_SHIFT;
          end
        end
        PORT_SHIFT: begin
          if (chip_select_n_in) begin
            state <= PORT_IDLE;
          end
        end
        default: state <= PORT_IDLE;
      endcase
    end
  end

  // R12 R3 msb first shift
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      shift <= '0;
    end else if (state == PORT_SHIFT && !chip_select_n_in && sck_rise) begin
      shift <= {shift[WIDTH-2:0], sdi_in};
    end
  end

  // R13 load on select rise
  assign load = (state == PORT_SHIFT) && cs_rise;

  amp_cfg_hold u_hold (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .load_in(load),
    .data_in(amp_configuration_t'(shift[CFG_WIDTH-1:0])),
    .hold_out(hold)
  );

  // R6 chain output
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sdo_out <= 1'b0;
      config_out <= amp_configuration_t'(CFG_RESET);
      mode_out <= decode(amp_configuration_t'(CFG_RESET));
      analog_oe_n_out <= 1'b0;
    end else begin
      sdo_out <= shift[WIDTH-1];
      config_out <= hold;
      mode_out <= decode(hold);
      // R1 active-low enable
      analog_oe_n_out <= hold.output_tristate;
    end
  end

  // select fall with sck low never opens an access
  AST_NO_START_SCK_LOW: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    (state == PORT_IDLE && cs_fall && !sck_in) |=> state == PORT_IDLE)
    else $error("access opened with sck low");

  AST_START_SCK_HIGH: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    (state == PORT_IDLE && cs_fall && sck_in && sck_q) |=> state == PORT_SHIFT)
    else $error("qualified select fall ignored");

  AST_SHIFT_IN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
    (state == PORT_SHIFT && !chip_select_n_in && sck_rise)
      |=> shift[0] == $past(sdi_in) && shift[WIDTH-1:1] == $past(shift[WIDTH-2:0]))
    else $error("serial bit not shifted in");

  AST_HOLD_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    (state == PORT_IDLE) |=> $stable(shift))
    else $error("shift register moved while idle");

  sequence s_load;
    state == PORT_SHIFT ##1 cs_rise;
  endsequence

  AST_LOAD_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
    s_load |=> ##1 config_out == amp_configuration_t'($past(shift, 2)))
    else $error("holding register not loaded on select rise");

  AST_TRISTATE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    config_out.output_tristate |-> analog_oe_n_out && !mode_out.out_enable)
    else $error("outputs active in tristate mode");

  AST_NULL_UNITY: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    (config_out.offset_null_sel && !config_out.output_tristate)
      |-> mode_out.gain_sel == SEL_UNITY && !mode_out.atten_path && !mode_out.amp_path)
    else $error("null mode not at unity");

  AST_ATTEN_GAIN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    (config_out[2:0] == 3'h0)
      |-> mode_out.gain_sel == {1'b0, config_out.gain_hi, config_out.gain_lo})
    else $error("attenuation gain wrong");

  AST_SDO: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    ##1 sdo_out == $past(shift[WIDTH-1]))
    else $error("chain output wrong");

  // converter-only starts and sck edges at the fall never open an access
  sequence s_refused_fall;
    state == PORT_IDLE && cs_fall && !(sck_q && sck_in);
  endsequence

  AST_NO_START_SCK_EDGE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    s_refused_fall |=> state == PORT_IDLE)
    else $error("access opened without sck high");

  AST_KEEP_HOLD_IDLE: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    (state == PORT_IDLE) |=> $stable(hold))
    else $error("holding register moved while idle");

  AST_SHIFT_STILL: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R12
    (state == PORT_SHIFT && !sck_rise) |=> $stable(shift))
    else $error("shift register moved without sck rise");

  AST_MODE_FROM_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
    $changed(config_out) |-> $past(load, 2))
    else $error("applied word changed without a load");

  AST_ACTIVE_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
    !config_out.output_tristate |-> !analog_oe_n_out && mode_out.out_enable)
    else $error("outputs off with tristate bit clear");

  AST_AMP_GAIN: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    (config_out[2:0] == 3'h4)
      |-> mode_out.amp_path && !mode_out.atten_path
        && mode_out.gain_sel == {2'b10, config_out.gain_lo})
    else $error("amplification gain wrong");

  AST_TRISTATE_PATHS: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    config_out.output_tristate |-> mode_out == amp_mode_t'({SEL_NONE, 4'b0000}))
    else $error("signal path left on in tristate mode");

  AST_RESET_ZERO: assert property (@(posedge clk_in) // R14
    !rst_n_in |=> config_out == amp_configuration_t'(CFG_RESET) && !analog_oe_n_out)
    else $error("applied word not cleared by reset");
endmodule

/* bench/spi_host_model.sv */
// spi_host_model: serial host on the configuration port pins
// assumes pins change at falling clk_in edges
`timescale 1ns/10ps
module spi_host_model
  import amp_cfg_pkg::*;
(
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic sdi_out
);
  initial begin
    sck_out = 1'b1;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // idle sck level picks access kind
  task automatic open_frame(input logic lvl);
    sck_out = lvl;
    wait_clk(3);
    cs_n_out = 1'b0;
    wait_clk(3);
  endtask
  task automatic shift5(input amp_configuration_t w, output amp_configuration_t seen);
    for (int i = CFG_WIDTH - 1; i >= 0; i--) begin
      sck_out = 1'b0;
      sdi_out = w[i];
      wait_clk(3);
      seen[i] = sdo_in;
      sck_out = 1'b1;
      wait_clk(3);
    end
  endtask
  // one shared select, raised after whole frame
  task automatic close_frame();
    wait_clk(3);
    cs_n_out = 1'b1;
    // released line must not keep its last value
    sdi_out = ~sdi_out;
    wait_clk(6);
  endtask
endmodule

/* bench/test_amp_config_serial_port.sv */
// test_amp_config_serial_port: writes every word, refused and chained frames
// assumes spi_host_model drives the serial pins
`timescale 1ns/10ps
module test_amp_config_serial_port;
  import amp_cfg_pkg::*;
  logic clk_in;
  logic rst_n_in;
  logic sck;
  logic cs_n;
  logic sdi;
  logic sdo_out;
  logic analog_oe_n_out;
  logic [6:0] mk;
  amp_configuration_t config_out;
  amp_configuration_t seen;
  amp_configuration_t last;
  amp_mode_t mode_out;
  int n_mismatch = 0;
  int n_compared = 0;
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  spi_host_model host (.clk_in(clk_in), .sdo_in(sdo_out), .sck_out(sck), .cs_n_out(cs_n),
    .sdi_out(sdi));
  amp_config_serial_port uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck),
    .chip_select_n_in(cs_n), .sdi_in(sdi), .sdo_out(sdo_out), .config_out(config_out),
    .mode_out(mode_out), .analog_oe_n_out(analog_oe_n_out));
  task automatic check(input logic [6:0] got, input logic [6:0] want);
    n_compared++;
    if (got !== want) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, got, want);
    end
  endtask
  function automatic amp_mode_t exp_mode(input amp_configuration_t w);
    amp_mode_t m;
    m.gain_sel = w.amplify_enable ? {2'b10, w.gain_lo} : {1'b0, w.gain_hi, w.gain_lo};
    m.atten_path = !w.amplify_enable;
    m.amp_path = w.amplify_enable;
    m.null_path = 1'b0;
    m.out_enable = 1'b1;
    if (w.offset_null_sel) begin
      m = {SEL_UNITY, 4'b0011};
    end
    if (w.output_tristate) begin
      m.gain_sel = SEL_NONE;
      m.out_enable = 1'b0;
    end
    return m;
  endfunction
  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // ample margin over about 1600 cycles of traffic
    #200us;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    rst_n_in = 1'b0;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    check(config_out, CFG_RESET);
    check(mode_out, {SEL_G0096, 4'b1001});
    check({analog_oe_n_out, sdo_out}, 7'h00);
    $display("test reset done");
    last = CFG_RESET;
    for (int w = 0; w < 32; w++) begin
      host.open_frame(1'b1);
      host.shift5(w[4:0], seen);
      host.close_frame();
      mk = w[0] ? 7'h71 : 7'h7f;
      check(seen, last);
      check(config_out, w[4:0]);
      check(mode_out & mk, exp_mode(w[4:0]) & mk);
      check(analog_oe_n_out, w[0]);
      last = w[4:0];
    end
    $display("test all words done");
    host.open_frame(1'b0);
    host.shift5(5'h0a, seen);
    host.close_frame();
    check({analog_oe_n_out, config_out}, 7'h3f);
    $display("test refused frame done");
    host.open_frame(1'b1);
    host.shift5(5'h0a, seen);
    check(seen, 5'h1f);
    host.shift5(5'h12, seen);
    check(seen, 5'h0a);
    host.close_frame();
    check(config_out, 5'h12);
    $display("test chain done");
    rst_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    @(negedge clk_in);
    check(config_out, CFG_RESET);
    check(mode_out, {SEL_G0096, 4'b1001});
    check({analog_oe_n_out, sdo_out}, 7'h00);
    host.open_frame(1'b1);
    host.shift5(5'h14, seen);
    check(seen, CFG_RESET);
    host.close_frame();
    check(config_out, 5'h14);
    check(mode_out, exp_mode(5'h14));
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
